// File: src/status_pkg.sv
// Purpose: shared constants and types for the instrument status reporting block
// Assumes: one clock domain, all event sources are logic on that clock
// Notes: byte selector and command codes are shared with the command parser

package status_pkg;

	// ==========================================================
	// byte selectors and commands
	typedef enum logic [1:0] {
		SEL_SERIAL_POLL = 2'h0,
		SEL_STD_EVENT = 2'h1,
		SEL_CONDITION = 2'h2,
		SEL_FAULT = 2'h3
	} byte_sel_e;

	typedef enum logic [2:0] {
		OP_MASK_WRITE = 3'h0,
		OP_MASK_READ = 3'h1,
		OP_STATUS_READ = 3'h2,
		OP_CLEAR_STATUS = 3'h3
	} cmd_op_e;

	typedef struct packed {
		logic valid;
		cmd_op_e op;
		byte_sel_e sel;
		logic whole;
		logic [2:0] bit_idx;
		logic [7:0] value;
	} cmd_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rsp_s;

	typedef struct packed {
		logic in_queue_overflow;
		logic out_queue_overflow;
		logic exec_error;
		logic illegal_command;
		logic user_panel_request;
		logic reserve_or_input_overload;
		logic filter_overload;
		logic output_overload;
		logic reference_lock_lost;
		logic time_constant_changed;
		logic trigger_received;
		logic backup_failed;
		logic ram_test_failed;
		logic rom_test_failed;
		logic bus_transfer_aborted;
		logic dsp_test_failed;
		logic math_error;
	} event_s;

	// ==========================================================
	// serial-poll bit positions
	localparam int SP_ACQ_IDLE = 0;
	localparam int SP_CMD_IDLE = 1;
	localparam int SP_FAULT = 2;
	localparam int SP_CONDITION = 3;
	localparam int SP_OUT_AVAIL = 4;
	localparam int SP_STD_EVENT = 5;
	localparam int SP_SERVICE = 6;

	// standard event bit positions
	localparam int SE_IN_OVF = 0;
	localparam int SE_OUT_OVF = 2;
	localparam int SE_EXEC_ERR = 4;
	localparam int SE_ILLEGAL = 5;
	localparam int SE_PANEL = 6;
	localparam int SE_POWER_ON = 7;

	// condition bit positions
	localparam int CN_RSV_INPUT = 0;
	localparam int CN_FILTER = 1;
	localparam int CN_OUTPUT = 2;
	localparam int CN_UNLOCK = 3;
	localparam int CN_RANGE = 4;
	localparam int CN_TIME_CONST = 5;
	localparam int CN_TRIGGER = 6;

	// fault bit positions
	localparam int FL_BACKUP = 1;
	localparam int FL_RAM = 2;
	localparam int FL_ROM = 4;
	localparam int FL_BUS_ABORT = 5;
	localparam int FL_DSP = 6;
	localparam int FL_MATH = 7;

	// detection frequency range threshold, in Hz
	localparam int RANGE_THRESHOLD_HZ = 200;

	// ==========================================================
	// reset values
	localparam logic [7:0] STD_EVENT_RESET = 8'h80;
	localparam logic [7:0] EVENT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] SERIAL_POLL_RESET = 8'h00;

endpackage : status_pkg

// File: src/instrument_status_reporting.sv
// Purpose: status bytes, enable masks and service request of the instrument
// Assumes: commands arrive already parsed, one per cycle at most, on ref_clk
// Notes: event inputs are one-cycle pulses or levels; both latch the same way
`timescale 1ns/1ps

module instrument_status_reporting
	import status_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire cmd_s cmd,
	input wire event_s events,
	input wire logic acquisition_idle,
	input wire logic command_idle,
	input wire logic output_buffer_nonempty,
	input wire logic freq_above_threshold,
	output rsp_s rsp,
	output logic [7:0] serial_poll_summary,
	output logic [7:0] standard_event_flags,
	output logic [7:0] instrument_condition_flags,
	output logic [7:0] fault_flags,
	output logic service_request
);

	// ==========================================================
	// decoding helpers
	function automatic logic [7:0] bit_onehot(input logic [2:0] idx);
		logic [7:0] v;
		v = 8'h00;
		v[idx] = 1'b1;
		return v;
	endfunction : bit_onehot

	function automatic logic [7:0] pick(input logic [7:0] b, input logic whole,
		input logic [2:0] idx);
		logic [7:0] v;
		v = whole ? b : {7'h00, b[idx]};
		return v;
	endfunction : pick

	// one summary bit: any flag that its enable mask lets through
	function automatic logic any_enabled(input logic [7:0] flags, input logic [7:0] enables);
		logic hit;
		hit = |(flags & enables);
		return hit;
	endfunction : any_enabled

	// whole-byte write, or a single bit taken from value[0]
	function automatic logic [7:0] mask_next(input logic [7:0] cur, input logic whole,
		input logic [2:0] idx, input logic [7:0] val);
		logic [7:0] v;
		v = cur;
		if (whole)
			v = val;
		else
			v[idx] = val[0];
		return v;
	endfunction : mask_next

	// ==========================================================
	// event set vectors; index 0 standard, 1 condition, 2 fault
	logic [7:0] set_vec [3];
	logic [7:0] clr_vec [3];
	logic [7:0] evt_q [3];
	logic [7:0] evt_d [3];
	logic range_prev_q;
	logic range_prev_d;
	logic range_armed_q;
	logic range_armed_d;
	logic range_cross;

	assign range_cross = range_armed_q & (freq_above_threshold ^ range_prev_q);

	// ==========================================================
	// standard event set vector
	always_comb
	begin
		set_vec[0] = 8'h00;
		set_vec[0][SE_IN_OVF] = events.in_queue_overflow;
		set_vec[0][SE_OUT_OVF] = events.out_queue_overflow;
		set_vec[0][SE_EXEC_ERR] = events.exec_error;
		set_vec[0][SE_ILLEGAL] = events.illegal_command;
		set_vec[0][SE_PANEL] = events.user_panel_request;
	end

	// ==========================================================
	// condition set vector; the range bit comes from the crossing detector
	always_comb
	begin
		set_vec[1] = 8'h00;
		set_vec[1][CN_RSV_INPUT] = events.reserve_or_input_overload;
		set_vec[1][CN_FILTER] = events.filter_overload;
		set_vec[1][CN_OUTPUT] = events.output_overload;
		set_vec[1][CN_UNLOCK] = events.reference_lock_lost;
		set_vec[1][CN_RANGE] = range_cross;
		set_vec[1][CN_TIME_CONST] = events.time_constant_changed;
		set_vec[1][CN_TRIGGER] = events.trigger_received;
	end

	// ==========================================================
	// fault set vector; bits 0 and 3 have no source and read zero
	always_comb
	begin
		set_vec[2] = 8'h00;
		set_vec[2][FL_BACKUP] = events.backup_failed;
		set_vec[2][FL_RAM] = events.ram_test_failed;
		set_vec[2][FL_ROM] = events.rom_test_failed;
		set_vec[2][FL_DSP] = events.dsp_test_failed;
		set_vec[2][FL_BUS_ABORT] = events.bus_transfer_aborted;
		set_vec[2][FL_MATH] = events.math_error;
	end

	// ==========================================================
	// clear decode: clear-status and clear-on-read
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			clr_vec[i] = 8'h00;
		end
		if (cmd.valid)
		begin
			unique case (cmd.op)
				OP_CLEAR_STATUS:
				begin
					for (int i = 0; i < 3; i++)
					begin
						clr_vec[i] = 8'hff;
					end
				end
				OP_STATUS_READ:
				begin
					if (cmd.sel != SEL_SERIAL_POLL)
					begin
						clr_vec[2'(cmd.sel) - 2'h1] = cmd.whole ? 8'hff : bit_onehot(cmd.bit_idx);
					end
				end
				OP_MASK_WRITE, OP_MASK_READ:
				begin
				end
				// op codes above clear status are ignored, never trusted
				default:
				begin
				end
			endcase
		end
	end

	// ==========================================================
	// latching event bytes; a set in the clearing cycle survives
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_evt
			always_comb
			begin
				evt_d[g] = (evt_q[g] & ~clr_vec[g]) | set_vec[g];
			end

			if (g == 0)
			begin : g_std
				// power-on sets bit 7 through the reset value
				always_ff @(posedge ref_clk or negedge arst_n)
				begin
					if (!arst_n)
					begin
						evt_q[g] <= STD_EVENT_RESET;
					end
					else
					begin
						evt_q[g] <= evt_d[g];
					end
				end
			end
			else
			begin : g_other
				always_ff @(posedge ref_clk or negedge arst_n)
				begin
					if (!arst_n)
					begin
						evt_q[g] <= EVENT_RESET;
					end
					else
					begin
						evt_q[g] <= evt_d[g];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// range tracker; armed after the first sample so reset is no crossing
	always_comb
	begin
		range_prev_d = freq_above_threshold;
		range_armed_d = 1'b1;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			range_prev_q <= 1'b0;
			range_armed_q <= 1'b0;
		end
		else
		begin
			range_prev_q <= range_prev_d;
			range_armed_q <= range_armed_d;
		end
	end

	// ==========================================================
	// enable masks, indexed by byte selector
	logic [7:0] mask_q [4];
	logic [7:0] mask_d [4];

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			mask_d[i] = mask_q[i];
		end
		if (cmd.valid && cmd.op == OP_MASK_WRITE)
		begin
			mask_d[cmd.sel] = mask_next(mask_q[cmd.sel], cmd.whole, cmd.bit_idx, cmd.value);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 4; i++)
			begin
				mask_q[i] <= MASK_RESET;
			end
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				mask_q[i] <= mask_d[i];
			end
		end
	end

	// ==========================================================
	// serial-poll summary; follows its sources with one cycle of lag
	logic [7:0] spoll_q;
	logic [7:0] spoll_d;
	logic [7:0] spoll_base;

	always_comb
	begin
		spoll_base = 8'h00;
		spoll_base[SP_ACQ_IDLE] = acquisition_idle;
		spoll_base[SP_CMD_IDLE] = command_idle;
		spoll_base[SP_FAULT] = any_enabled(evt_q[2], mask_q[SEL_FAULT]);
		spoll_base[SP_CONDITION] = any_enabled(evt_q[1], mask_q[SEL_CONDITION]);
		spoll_base[SP_OUT_AVAIL] = output_buffer_nonempty;
		spoll_base[SP_STD_EVENT] = any_enabled(evt_q[0], mask_q[SEL_STD_EVENT]);
		spoll_d = spoll_base;
		spoll_d[SP_SERVICE] = |(spoll_base & mask_q[SEL_SERIAL_POLL] & ~bit_onehot(3'(SP_SERVICE)));
		spoll_d[7] = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			spoll_q <= SERIAL_POLL_RESET;
		end
		else
		begin
			spoll_q <= spoll_d;
		end
	end

	// ==========================================================
	// query answers, one cycle after the command is taken
	rsp_s rsp_q;
	rsp_s rsp_d;
	logic [7:0] status_sel;

	always_comb
	begin
		unique case (cmd.sel)
			SEL_SERIAL_POLL: status_sel = spoll_q;
			SEL_STD_EVENT: status_sel = evt_q[0];
			SEL_CONDITION: status_sel = evt_q[1];
			SEL_FAULT: status_sel = evt_q[2];
		endcase
	end

	// a read answers with the byte as it stood before its own clear
	always_comb
	begin
		rsp_d.valid = 1'b0;
		rsp_d.data = rsp_q.data;
		if (cmd.valid)
		begin
			unique case (cmd.op)
				OP_STATUS_READ:
				begin
					rsp_d.valid = 1'b1;
					rsp_d.data = pick(status_sel, cmd.whole, cmd.bit_idx);
				end
				OP_MASK_READ:
				begin
					rsp_d.valid = 1'b1;
					rsp_d.data = pick(mask_q[cmd.sel], cmd.whole, cmd.bit_idx);
				end
				OP_MASK_WRITE, OP_CLEAR_STATUS:
				begin
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rsp_q <= '0;
		end
		else
		begin
			rsp_q <= rsp_d;
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	assign rsp = rsp_q;
	assign serial_poll_summary = spoll_q;
	assign standard_event_flags = evt_q[0];
	assign instrument_condition_flags = evt_q[1];
	assign fault_flags = evt_q[2];
	assign service_request = spoll_q[SP_SERVICE];

endmodule : instrument_status_reporting

// File: verif/status_checker.sv
// Purpose: port-level checks for the status reporting block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: summary bits are level copies, one cycle behind their sources
`timescale 1ns/1ps

module status_checker
	import status_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire cmd_s cmd,
	input wire event_s events,
	input wire logic acquisition_idle,
	input wire logic command_idle,
	input wire logic output_buffer_nonempty,
	input wire logic freq_above_threshold,
	input wire rsp_s rsp,
	input wire logic [7:0] serial_poll_summary,
	input wire logic [7:0] standard_event_flags,
	input wire logic [7:0] instrument_condition_flags,
	input wire logic [7:0] fault_flags,
	input wire logic service_request
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	// ==========================================================
	// serial-poll summary
	sp_top_zero_a: assert property (serial_poll_summary[7] == 1'b0)
		else $error("serial poll bit 7 set");
	srq_mirror_a: assert property (service_request == serial_poll_summary[6])
		else $error("service request differs from bit 6");
	// first edge after release still shows the reset value, hence the past guard
	acq_follow_a: assert property ($past(arst_n) |->
		serial_poll_summary[0] == $past(acquisition_idle))
		else $error("acquisition idle bit wrong");
	cmd_follow_a: assert property ($past(arst_n) |->
		serial_poll_summary[1] == $past(command_idle))
		else $error("command idle bit wrong");
	buf_follow_a: assert property ($past(arst_n) |->
		serial_poll_summary[4] == $past(output_buffer_nonempty))
		else $error("output available bit wrong");

	// ==========================================================
	// event latching and clearing
	exec_latch_a: assert property (events.exec_error |=> standard_event_flags[4])
		else $error("execution error not latched");
	trig_latch_a: assert property (events.trigger_received |=> instrument_condition_flags[6])
		else $error("trigger not latched");
	math_latch_a: assert property (events.math_error |=> fault_flags[7])
		else $error("math error not latched");
	flag_hold_a: assert property (fault_flags[1] && !cmd.valid |=> fault_flags[1])
		else $error("fault bit dropped without read");
	clear_all_a: assert property (cmd.valid && cmd.op == OP_CLEAR_STATUS && events == '0
		&& $stable(freq_above_threshold) |=> standard_event_flags == 8'h00
		&& instrument_condition_flags == 8'h00 && fault_flags == 8'h00)
		else $error("clear status left bits set");
	set_wins_a: assert property (cmd.valid && cmd.op == OP_CLEAR_STATUS
		&& events.in_queue_overflow |=> standard_event_flags[0])
		else $error("event lost to a same-cycle clear");
	rsp_pulse_a: assert property ($past(arst_n) |->
		rsp.valid == $past(cmd.valid && (cmd.op == OP_STATUS_READ || cmd.op == OP_MASK_READ)))
		else $error("answer pulse out of step with query");

	cover property (events.exec_error ##2 service_request);
	cover property (cmd.valid && cmd.op == OP_CLEAR_STATUS);
	cover property (rsp.valid);
	cover property (cmd.valid && cmd.op == OP_CLEAR_STATUS && events != '0);
	cover property (cmd.valid && cmd.op == OP_MASK_READ && !cmd.whole);
endmodule : status_checker

bind instrument_status_reporting status_checker chk_u (
	.ref_clk,
	.arst_n,
	.cmd,
	.events,
	.acquisition_idle,
	.command_idle,
	.output_buffer_nonempty,
	.freq_above_threshold,
	.rsp,
	.serial_poll_summary,
	.standard_event_flags,
	.instrument_condition_flags,
	.fault_flags,
	.service_request
);

// File: verif/host_model.sv
// Purpose: remote host that issues parsed commands and collects answers
// Assumes: answer arrives exactly one cycle after the command is taken
// Notes: one command per call, released after the taking edge
`timescale 1ns/1ps

module host_model
	import status_pkg::*;
(
	input wire logic ref_clk,
	input wire rsp_s rsp,
	output cmd_s cmd
);
	initial cmd = '0;

	task automatic issue(input cmd_op_e op, input byte_sel_e sel, input logic whole,
		input logic [2:0] idx, input logic [7:0] val, output logic [7:0] data);
		@(posedge ref_clk);
		cmd <= '{1'b1, op, sel, whole, idx, val};
		@(posedge ref_clk);
		cmd <= '0;
		#1;
		data = rsp.valid ? rsp.data : 8'hee;
	endtask : issue
endmodule : host_model

// File: verif/instrument_status_reporting_tb.sv
// Purpose: directed test of status bytes, masks and service request
// Assumes: host_model drives all commands
// Notes: checks sampled 1 ns after the edge so register updates have landed
`timescale 1ns/1ps

module instrument_status_reporting_tb;
	import status_pkg::*;

	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	cmd_s cmd;
	rsp_s rsp;
	event_s events = '0;
	logic acquisition_idle = 1'b0;
	logic command_idle = 1'b0;
	logic output_buffer_nonempty = 1'b0;
	logic freq_above_threshold = 1'b0;
	logic [7:0] sp;
	logic [7:0] se;
	logic [7:0] cn;
	logic [7:0] fl;
	logic srq;
	logic [7:0] d;
	int mismatches = 0;
	int num_checks = 0;
	// {selector, bit} of each event field, least significant field first
	logic [4:0] map [17] = '{5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h1a, 5'h19, 5'h16, 5'h15, 5'h13,
		5'h12, 5'h11, 5'h10, 5'h0e, 5'h0d, 5'h0c, 5'h0a, 5'h08};

	always #20 ref_clk = ~ref_clk;

	instrument_status_reporting dut_u (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.cmd(cmd),
		.events(events),
		.acquisition_idle(acquisition_idle),
		.command_idle(command_idle),
		.output_buffer_nonempty(output_buffer_nonempty),
		.freq_above_threshold(freq_above_threshold),
		.rsp(rsp),
		.serial_poll_summary(sp),
		.standard_event_flags(se),
		.instrument_condition_flags(cn),
		.fault_flags(fl),
		.service_request(srq)
	);

	host_model host_u (
		.ref_clk(ref_clk),
		.rsp(rsp),
		.cmd(cmd)
	);

	// ==========================================================
	// helpers
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_n

	task automatic pulse(input int k);
		@(posedge ref_clk);
		events <= event_s'(17'h1 << k);
		@(posedge ref_clk);
		events <= '0;
		#1;
	endtask : pulse

	function automatic logic [7:0] flag_byte(input logic [1:0] sel);
		case (sel)
			2'h1: return se;
			2'h2: return cn;
			default: return fl;
		endcase
	endfunction : flag_byte

	task automatic give_verdict;
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// tests
	initial
	begin
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		wait_n(1);
		check("power on", se, 8'h80);
		host_u.issue(OP_CLEAR_STATUS, SEL_SERIAL_POLL, 1'b1, 3'h0, 8'h00, d);
		check("clear", se, 8'h00);
		@(posedge ref_clk);
		{acquisition_idle, command_idle, output_buffer_nonempty} <= 3'h7;
		wait_n(2);
		check("sp sources", sp, 8'h13);
		@(posedge ref_clk);
		{acquisition_idle, command_idle, output_buffer_nonempty} <= 3'h0;
		wait_n(2);
		check("sp idle", sp, 8'h00);
		// a crossing either way latches the range bit
		for (int i = 0; i < 2; i++)
		begin
			@(posedge ref_clk);
			freq_above_threshold <= ~freq_above_threshold;
			wait_n(2);
			check("range", cn, 8'h10);
			host_u.issue(OP_CLEAR_STATUS, SEL_CONDITION, 1'b1, 3'h0, 8'h00, d);
			check("range clear", cn, 8'h00);
		end
		for (int k = 0; k < 17; k++)
		begin
			pulse(k);
			check("event flag", flag_byte(map[k][4:3]), 8'h01 << map[k][2:0]);
			host_u.issue(OP_STATUS_READ, byte_sel_e'(map[k][4:3]), 1'b1, 3'h0, 8'h00, d);
			check("status read", d, 8'h01 << map[k][2:0]);
			check("read clears", flag_byte(map[k][4:3]), 8'h00);
		end
		host_u.issue(OP_MASK_WRITE, SEL_STD_EVENT, 1'b1, 3'h0, 8'h10, d);
		host_u.issue(OP_MASK_WRITE, SEL_SERIAL_POLL, 1'b0, 3'h5, 8'h01, d);
		host_u.issue(OP_MASK_WRITE, SEL_FAULT, 1'b1, 3'h0, 8'h80, d);
		host_u.issue(OP_MASK_WRITE, SEL_CONDITION, 1'b0, 3'h6, 8'h01, d);
		host_u.issue(OP_MASK_READ, SEL_SERIAL_POLL, 1'b1, 3'h0, 8'h00, d);
		check("sp mask", d, 8'h20);
		host_u.issue(OP_MASK_READ, SEL_CONDITION, 1'b0, 3'h6, 8'h00, d);
		check("cond mask bit", d, 8'h01);
		pulse(14);
		wait_n(2);
		check("std summary", sp, 8'h60);
		pulse(0);
		pulse(6);
		wait_n(2);
		check("fault cond summary", sp, 8'h6c);
		check("srq", {7'h00, srq}, 8'h01);
		host_u.issue(OP_STATUS_READ, SEL_SERIAL_POLL, 1'b1, 3'h0, 8'h00, d);
		check("sp read", d, 8'h6c);
		check("sp read keeps", fl, 8'h80);
		host_u.issue(OP_STATUS_READ, SEL_STD_EVENT, 1'b0, 3'h4, 8'h00, d);
		check("bit read", d, 8'h01);
		wait_n(2);
		check("srq off", sp, 8'h0c);
		// an event in the clearing cycle survives the clear
		fork
			host_u.issue(OP_CLEAR_STATUS, SEL_SERIAL_POLL, 1'b1, 3'h0, 8'h00, d);
			pulse(16);
		join
		check("set wins", se, 8'h01);
		check("clear cond", cn, 8'h00);
		check("clear fault", fl, 8'h00);
		host_u.issue(OP_MASK_READ, SEL_FAULT, 1'b1, 3'h0, 8'h00, d);
		check("mask kept", d, 8'h80);
		give_verdict();
	end

	initial
	begin
		#50us;
		mismatches++;
		give_verdict();
	end
endmodule : instrument_status_reporting_tb
